/* File: bench/comp_regs_tb.sv */
`timescale 1ns/1ps
`include "comp_regs_defines.svh"
module comp_regs_tb
  import comp_regs_pkg::*;
;
  logic        ref_clk, sys_rst, wr, rd, comp_level, sample_task, irq, comp_on;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  logic [2:0]  input_sel, ref_sel, extref_sel;
  int          errors, check_count;

  comp_regs i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .comp_level(comp_level), .sample_task(sample_task), .rdata(rdata), .irq(irq), .comp_on(comp_on),
    .input_sel(input_sel), .ref_sel(ref_sel), .extref_sel(extref_sel));

  // free-running 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // strobes drop one edge later, so back-to-back calls never drive wr twice in one step
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so look there
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic sample(input logic lvl);
    @(posedge ref_clk);
    comp_level  <= lvl;
    sample_task <= 1'b1;
    @(posedge ref_clk);
    sample_task <= 1'b0;
  endtask

  task automatic t_reset();
    rd_chk(`OFS_INT_DISABLE, 32'h0);
    rd_chk(`OFS_INT_ENABLE, 32'h0);
    rd_chk(`OFS_RESULT, 32'h0);
    rd_chk(`OFS_ENABLE, 32'h0);
    rd_chk(`OFS_INPUT_SEL, 32'h0);
    rd_chk(`OFS_REF_SEL, 32'h0000_0004);
    chk({29'h0, ref_sel}, 32'h0000_0004);
    rd_chk(`OFS_TASKS, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_sample();
    wr_reg(`OFS_ENABLE, 32'h1);
    settle();
    chk({31'h0, comp_on}, 32'h0);
    wr_reg(`OFS_ENABLE, 32'h2);
    settle();
    chk({31'h0, comp_on}, 32'h1);
    sample(1'b1);
    rd_chk(`OFS_RESULT, 32'h1);
    @(posedge ref_clk);
    comp_level <= 1'b0;
    rd_chk(`OFS_RESULT, 32'h1);
    sample(1'b0);
    rd_chk(`OFS_RESULT, 32'h0);
    $display("sample test done");
  endtask

  task automatic t_interrupt_enable_shared();
    wr_reg(`OFS_INT_SET, 32'hf);
    wr_reg(`OFS_INT_DISABLE, 32'h5);
    rd_chk(`OFS_INT_DISABLE, 32'ha);
    rd_chk(`OFS_INT_ENABLE, 32'ha);
    wr_reg(`OFS_INT_DISABLE, 32'h8);
    rd_chk(`OFS_INT_DISABLE, 32'h2);
    wr_reg(`OFS_INT_DISABLE, 32'h0);
    rd_chk(`OFS_INT_DISABLE, 32'h2);
    wr_reg(`OFS_INT_ENABLE, 32'h5);
    rd_chk(`OFS_INT_DISABLE, 32'h5);
    // leave only the down enable set for the interrupt test
    wr_reg(`OFS_INT_ENABLE, 32'h2);
    rd_chk(`OFS_INT_ENABLE, 32'h2);
    $display("enable test done");
  endtask

  // only the down enable is left set; a falling level must raise irq
  task automatic t_irq();
    wr_reg(`OFS_EVT_MASK, 32'h2);
    wr_reg(`OFS_EVT_STATUS, 32'hf);
    settle();
    chk({31'h0, irq}, 32'h0);
    @(posedge ref_clk);
    comp_level <= 1'b1;
    @(posedge ref_clk);
    comp_level <= 1'b0;
    settle();
    chk({31'h0, irq}, 32'h1);
    wr_reg(`OFS_INT_DISABLE, 32'h2);
    settle();
    chk({31'h0, irq}, 32'h0);
    wr_reg(`OFS_INT_SET, 32'h2);
    settle();
    chk({31'h0, irq}, 32'h1);
    wr_reg(`OFS_EVT_MASK, 32'h0);
    wr_reg(`OFS_EVT_STATUS, 32'h2);
    wr_reg(`OFS_EVT_MASK, 32'h2);
    settle();
    chk({31'h0, irq}, 32'h0);
    $display("irq test done");
  endtask

  task automatic t_sel();
    logic [2:0] refs [4] = '{3'h0, 3'h1, 3'h2, 3'h5};
    for (int i = 0; i < 8; i++) begin
      wr_reg(`OFS_INPUT_SEL, 32'(i));
      wr_reg(`OFS_EXTREF_SEL, 32'(7 - i));
      settle();
      chk({29'h0, input_sel}, 32'(i));
      chk({29'h0, extref_sel}, 32'(7 - i));
      rd_chk(`OFS_INPUT_SEL, 32'(i));
      rd_chk(`OFS_EXTREF_SEL, 32'(7 - i));
    end
    foreach (refs[k]) begin
      wr_reg(`OFS_REF_SEL, {29'h0, refs[k]});
      settle();
      chk({29'h0, ref_sel}, {29'h0, refs[k]});
      rd_chk(`OFS_REF_SEL, {29'h0, refs[k]});
    end
    $display("select test done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    {wr, rd, comp_level, sample_task, addr, wdata} = '0;
    sys_rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_sample();
    t_interrupt_enable_shared();
    t_irq();
    t_sel();
    final_report();
  end

  // watchdog: the tests need well under 10 us
  initial begin
    #100us;
    errors++;
    final_report();
  end
endmodule // comp_regs_tb

/* File: verilog/comp_regs.sv */
`timescale 1ns/1ps
`include "comp_regs_defines.svh"
module comp_regs
  import comp_regs_pkg::*;
(
  input  wire logic        ref_clk,     // 50 MHz clock
  input  wire logic        sys_rst,     // sync reset, active high
  input  wire logic [11:0] addr,        // byte address
  input  wire logic [31:0] wdata,       // write data
  input  wire logic        wr,          // write strobe
  input  wire logic        rd,          // read strobe
  input  wire logic        comp_level,  // analog core output, high when positive above negative
  input  wire logic        sample_task, // sample task pulse
  output logic [31:0]      rdata,       // read data, cycle after rd
  output logic             irq,         // level interrupt
  output logic             comp_on,     // analog core enable
  output logic [2:0]       input_sel,   // positive input channel, 7 half supply
  output logic [2:0]       ref_sel,     // single-ended reference source
  output logic [2:0]       extref_sel   // external reference channel
);
  regs_state_t cur;
  regs_state_t next_cur;
  logic [3:0]  evt;
  logic [3:0]  hw_evt;
  logic        running;

  assign running = cur.state == cmp_ready;

  event_detect u_evt (
    .running (running),
    .prev    (cur.last_level),
    .level   (comp_level),
    .evt     (evt)
  );

  // ready event fires the cycle the comparator turns on
  always_comb begin
    hw_evt    = evt;
    hw_evt[0] = cur.state == cmp_off && cur.enable == `ENABLE_ON;
  end

  // next state: bus decode, capture and sticky events
  always_comb begin
    next_cur = cur;
    next_cur.last_level = comp_level;
    case (cur.state)
      cmp_off: begin
        if (cur.enable == `ENABLE_ON) begin
          next_cur.state = cmp_ready;
        end
      end
      cmp_ready: begin
        if (cur.enable != `ENABLE_ON) begin
          next_cur.state = cmp_off;
        end
      end
      default: begin
        next_cur.state = cmp_off;
      end
    endcase
    // sample only counts while running, result held otherwise
    if (sample_task && running) begin
      next_cur.result = comp_level;
    end
    if (wr) begin
      case (addr)
        `OFS_INT_ENABLE:  next_cur.int_en = wdata[3:0];
        `OFS_INT_SET:     next_cur.int_en = cur.int_en | wdata[3:0];
        `OFS_INT_DISABLE: next_cur.int_en = cur.int_en & ~wdata[3:0];
        `OFS_ENABLE:      next_cur.enable = wdata[1:0];
        `OFS_INPUT_SEL:   next_cur.input_sel = wdata[2:0];
        `OFS_REF_SEL:     next_cur.ref_sel = wdata[2:0];
        `OFS_EXTREF_SEL:  next_cur.extref_sel = wdata[2:0];
        `OFS_EVT_STATUS:  next_cur.evt_status = cur.evt_status & ~wdata[3:0];
        `OFS_EVT_MASK:    next_cur.evt_mask = wdata[3:0];
        default: begin
        end
      endcase
    end
    // set wins over a same-cycle write-one clear
    next_cur.evt_status = next_cur.evt_status | hw_evt;
    next_cur.rdata = 32'h0000_0000;
    if (rd) begin
      case (addr)
        `OFS_INT_ENABLE,
        `OFS_INT_SET,
        `OFS_INT_DISABLE: next_cur.rdata = {28'h000_0000, cur.int_en};
        `OFS_RESULT:      next_cur.rdata = {31'h0000_0000, cur.result};
        `OFS_ENABLE:      next_cur.rdata = {30'h0000_0000, cur.enable};
        `OFS_INPUT_SEL:   next_cur.rdata = {29'h0000_0000, cur.input_sel};
        `OFS_REF_SEL:     next_cur.rdata = {29'h0000_0000, cur.ref_sel};
        `OFS_EXTREF_SEL:  next_cur.rdata = {29'h0000_0000, cur.extref_sel};
        `OFS_EVT_STATUS:  next_cur.rdata = {28'h000_0000, cur.evt_status};
        `OFS_EVT_MASK:    next_cur.rdata = {28'h000_0000, cur.evt_mask};
        default:          next_cur.rdata = 32'h0000_0000;
      endcase
    end
    // interrupt needs both the event mask and the event's enable
    next_cur.irq = |(next_cur.evt_status & next_cur.evt_mask & next_cur.int_en);
    next_cur.comp_on = next_cur.enable == `ENABLE_ON;
  end

  // single state register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cur            <= '0;
      cur.state      <= cmp_off;
      cur.ref_sel    <= `RST_REF_SEL;
    end else begin
      cur <= next_cur;
    end
  end

  assign rdata      = cur.rdata;
  assign irq        = cur.irq;
  assign comp_on    = cur.comp_on;
  assign input_sel  = cur.input_sel;
  assign ref_sel    = cur.ref_sel;
  assign extref_sel = cur.extref_sel;

  // disable bit write clears only the ones written
  disable_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr && addr == `OFS_INT_DISABLE |=> cur.int_en == ($past(cur.int_en) & ~$past(wdata[3:0])))
    else $error("disable write wrong");
  threshold_crossing_event_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr && addr == `OFS_INT_DISABLE && wdata[3] |=> !cur.int_en[3])
    else $error("threshold_crossing_event enable not cleared");
  disable_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd && addr == `OFS_INT_DISABLE |=> rdata == {28'h000_0000, $past(cur.int_en)})
    else $error("disable readback wrong");
  result_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !(sample_task && running) |=> $stable(cur.result))
    else $error("result changed without sample");
  result_value_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sample_task && running |=> cur.result == $past(comp_level))
    else $error("result not captured");
  enable_on_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr && addr == `OFS_ENABLE |=> comp_on == ($past(wdata[1:0]) == `ENABLE_ON))
    else $error("comp_on wrong");
  input_sel_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr && addr == `OFS_INPUT_SEL |=> input_sel == $past(wdata[2:0]))
    else $error("input select not stored");
  ref_sel_a: assert property (@(posedge ref_clk)
    sys_rst |=> ref_sel == `RST_REF_SEL)
    else $error("reference reset wrong");
  extref_sel_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr && addr == `OFS_EXTREF_SEL |=> extref_sel == $past(wdata[2:0]))
    else $error("extref select not stored");
  enable_reset_a: assert property (@(posedge ref_clk)
    sys_rst |=> cur.int_en == 4'h0 && !irq)
    else $error("enables not reset");
endmodule // comp_regs

/* File: verilog/comp_regs_defines.svh */
`ifndef COMP_REGS_DEFINES_SVH
`define COMP_REGS_DEFINES_SVH
`define OFS_INT_ENABLE     12'h300
`define OFS_INT_SET        12'h304
`define OFS_INT_DISABLE    12'h308
`define OFS_RESULT         12'h400
`define OFS_ENABLE         12'h500
`define OFS_INPUT_SEL      12'h504
`define OFS_REF_SEL        12'h508
`define OFS_EXTREF_SEL     12'h50c
`define OFS_EVT_STATUS     12'h600
`define OFS_EVT_MASK       12'h604
`define OFS_TASKS          12'h608
`define RST_REF_SEL        3'h4
`define ENABLE_ON          2'h2
`define INPUT_HALF_SUPPLY  3'h7
`define REF_EXTERNAL       3'h5
`define NUM_EVENTS         4
`endif

/* File: verilog/comp_regs_pkg.sv */
package comp_regs_pkg;
  typedef enum logic [1:0] {
    cmp_off,
    cmp_ready
  } cmp_state_t;
  typedef struct packed {
    cmp_state_t  state;
    logic [3:0]  int_en;
    logic [3:0]  evt_status;
    logic [3:0]  evt_mask;
    logic        result;
    logic [1:0]  enable;
    logic [2:0]  input_sel;
    logic [2:0]  ref_sel;
    logic [2:0]  extref_sel;
    logic        last_level;
    logic [31:0] rdata;
    logic        irq;
    logic        comp_on;
  } regs_state_t;
endpackage

/* File: verilog/event_detect.sv */
`timescale 1ns/1ps
`include "comp_regs_defines.svh"
module event_detect
  import comp_regs_pkg::*;
(
  input  wire logic       running,   // comparator enabled and ready
  input  wire logic       prev,      // level seen last cycle
  input  wire logic       level,     // live comparator output
  output logic [3:0]      evt        // bit0 ready (held 0 here, set in comp_regs), 1 down, 2 up, 3 threshold_crossing_event
);
  // edges only count while running so stale levels after enable raise nothing
  always_comb begin
    evt[0] = 1'b0;
    evt[1] = running & prev & ~level;
    evt[2] = running & ~prev & level;
    evt[3] = running & (prev ^ level);
  end
endmodule // event_detect
